// ### include/scan_chain_defines.vh
`ifndef SCAN_CHAIN_DEFINES_VH
`define SCAN_CHAIN_DEFINES_VH

// ****************************************
// chain geometry
// ****************************************
`define CHAIN_LEN        132
`define HIDDEN_CELLS     43
`define HIDDEN_TOP_POS   131
`define HIDDEN_LOW_POS   89
`define PORTB_TOP_POS    88
`define PORTB_LOW_POS    74
`define PORTB_PINS       5
`define CELLS_PER_PIN    3
`define LOW_LEN          74

// ****************************************
// cell offsets inside one pin group
// ****************************************
`define FF_VALUE_OFS     2
`define FF_DIR_OFS       1
`define FF_PLD_OFS       0

// ****************************************
// observe-only lower segment cells 60..63
// ****************************************
`define OBS_TOP_POS      63
`define OBS_LOW_POS      60

// ****************************************
// safe preload pattern for hidden cells 0..42
// bit i of the pattern is cell i
// ****************************************
`define HIDDEN_SAFE      43'h0c4_0220_0801

// ****************************************
// input synchroniser
// ****************************************
`define SYNC_STAGES      3
`define SYNC_WIDTH       12
`define SYNC_RESET       12'h000
`define CHAIN_RESET      132'h0

`endif

// ### src/boundary_scan_chain.v
`timescale 1ns/1ps
`default_nettype none
`include "scan_chain_defines.vh"

module boundary_scan_chain #(
  parameter CHAIN_LEN = `CHAIN_LEN
) (
  // clock and reset
  input  wire                     sys_clk,
  input  wire                     arst_n,
  // test access, all from the tck domain
  input  wire                     tck,
  input  wire                     tdi,
  input  wire                     bs_select,
  input  wire                     capture_dr,
  input  wire                     shift_dr,
  input  wire                     update_dr,
  input  wire                     extest_mode,
  output reg                      tdo,
  output reg                      tdo_oe,
  // hidden analog interface
  input  wire [`HIDDEN_CELLS-1:0] hidden_capture,
  output reg  [`HIDDEN_CELLS-1:0] hidden_internal_cell,
  output wire                     hidden_override,
  // port b pins 0..4
  input  wire [`PORTB_PINS-1:0]   pin_port_output_bit,
  input  wire [`PORTB_PINS-1:0]   pin_direction_bit,
  input  wire [`PORTB_PINS-1:0]   pb_pad_in,
  output wire [`PORTB_PINS-1:0]   pb_pad_out,
  output wire [`PORTB_PINS-1:0]   pb_pad_oe,
  output wire [`PORTB_PINS-1:0]   pb_pullup_en,
  // lower chain segment (rest of port b, ports d, c, a, reset cell)
  input  wire [`LOW_LEN-1:0]      low_capture,
  output wire [`LOW_LEN-1:0]      low_update
);

  // ****************************************
  // input synchronisers
  // ****************************************
  wire [`SYNC_WIDTH-1:0] raw_in;
  reg  [`SYNC_WIDTH-1:0] sync1;
  reg  [`SYNC_WIDTH-1:0] sync2;
  reg  [`SYNC_WIDTH-1:0] sync3;
  reg  [`SYNC_WIDTH-1:0] stable;

  assign raw_in = {pb_pad_in, extest_mode, update_dr, shift_dr,
                   capture_dr, bs_select, tdi, tck};

  // three stages; a level counts once stages two and three agree
  // a bit that disagrees keeps its old agreed level, so a level caught
  // half way through a change never reaches the tap decoding
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1  <= `SYNC_RESET;
      sync2  <= `SYNC_RESET;
      sync3  <= `SYNC_RESET;
      stable <= `SYNC_RESET;
    end else begin
      sync1  <= raw_in;
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= (stable & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
    end
  end

  wire                   tck_s     = stable[0];
  wire                   tdi_s     = stable[1];
  wire                   sel_s     = stable[2];
  wire                   cap_s     = stable[3];
  wire                   shf_s     = stable[4];
  wire                   upd_s     = stable[5];
  wire                   ext_s     = stable[6];
  wire [`PORTB_PINS-1:0] pad_s     = stable[11:7];

  // tck edges seen from the agreed level
  reg tck_prev;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      tck_prev <= 1'b0;
    else
      tck_prev <= tck_s;
  end

  wire tck_rise = tck_s & ~tck_prev;
  wire tck_fall = ~tck_s & tck_prev;

  // ****************************************
  // capture vector
  // ****************************************
  reg [CHAIN_LEN-1:0] cap_vec;
  integer p;

  // hidden cells on top, port b below, lower segment at the bottom
  // the pull inhibit cell captures the functional term, not the pad,
  // so it reads back what the port logic asks for
  always @* begin
    cap_vec = `CHAIN_RESET;
    for (p = 0; p < `HIDDEN_CELLS; p = p + 1)
      cap_vec[`HIDDEN_TOP_POS - p] = hidden_capture[p];
    for (p = 0; p < `PORTB_PINS; p = p + 1) begin
      cap_vec[`PORTB_LOW_POS + `CELLS_PER_PIN*(`PORTB_PINS-1-p)
              + `FF_VALUE_OFS] = pad_s[p];
      cap_vec[`PORTB_LOW_POS + `CELLS_PER_PIN*(`PORTB_PINS-1-p)
              + `FF_DIR_OFS] = pin_direction_bit[p];
      cap_vec[`PORTB_LOW_POS + `CELLS_PER_PIN*(`PORTB_PINS-1-p)
              + `FF_PLD_OFS] = pin_direction_bit[p] |
                               ~pin_port_output_bit[p];
    end
    // port a order kept by segment wiring
    cap_vec[`LOW_LEN-1:0] = low_capture;
  end

  // ****************************************
  // shift register and tdo
  // ****************************************
  reg [CHAIN_LEN-1:0] chain;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      chain <= `CHAIN_RESET;
    else if (sel_s && tck_rise && cap_s)
      chain <= cap_vec;
    else if (sel_s && tck_rise && shf_s)
      chain <= {tdi_s, chain[CHAIN_LEN-1:1]};
  end

  // tdo changes on the falling tck edge so the tester samples it clean
  // tdo_oe follows shift_dr, so the pad floats outside a shift
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= chain[0];
      tdo_oe <= sel_s & shf_s;
    end
  end

  // ****************************************
  // update latches
  // ****************************************
  reg  [CHAIN_LEN-1:0]     latch;
  wire [`HIDDEN_CELLS-1:0] chain_hidden;
  wire                     do_update = sel_s & upd_s & tck_fall;
  genvar                   g;

  // hidden cell p sits at chain position 131 - p; wired out here so the
  // clocked update below needs no loop variable
  generate
    for (g = 0; g < `HIDDEN_CELLS; g = g + 1) begin : g_hid
      assign chain_hidden[g] = chain[`HIDDEN_TOP_POS - g];
    end
  endgenerate

  // hidden latches reset to the safe pattern, so the analog side never
  // sees a contention code before the first update
  // update into latches
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch                <= `CHAIN_RESET;
      hidden_internal_cell <= `HIDDEN_SAFE;
    end else if (do_update) begin
      latch                <= chain;
      hidden_internal_cell <= chain_hidden;
    end
  end

  generate
    for (g = 0; g < `LOW_LEN; g = g + 1) begin : g_low
      if (g >= `OBS_LOW_POS && g <= `OBS_TOP_POS) begin : g_obs
        assign low_update[g] = 1'b0;
      end else begin : g_upd
        assign low_update[g] = latch[g];
      end
    end
  endgenerate

  // ****************************************
  // pin multiplexing
  // ****************************************
  // latches reach pins only in extest
  assign hidden_override = ext_s;

  generate
    for (g = 0; g < `PORTB_PINS; g = g + 1) begin : g_pin
      localparam BASE = `PORTB_LOW_POS + `CELLS_PER_PIN*(`PORTB_PINS-1-g);
      // latch cells drive value, enable, pull
      assign pb_pad_out[g]   = ext_s ? latch[BASE + `FF_VALUE_OFS]
                                     : pin_port_output_bit[g];
      assign pb_pad_oe[g]    = ext_s ? latch[BASE + `FF_DIR_OFS]
                                     : pin_direction_bit[g];
      assign pb_pullup_en[g] = ext_s ? ~latch[BASE + `FF_PLD_OFS]
                                     : ~(pin_direction_bit[g] |
                                         ~pin_port_output_bit[g]);
    end
  endgenerate

endmodule // boundary_scan_chain
`default_nettype wire

// ### dv/scan_tester.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// test controller model
// ****
module scan_tester (
  // tap levels; tck stands still between frames
  output var logic tck = 1'b0, tdi = 1'b0, bs_select = 1'b0,
  output var logic capture_dr = 1'b0, shift_dr = 1'b0, update_dr = 1'b0,
  // serial return
  input wire logic tdo
);
  logic b;
  // 400 ns period; tdo taken just before the fall, where it has settled
  task automatic tick(output logic t);
    #100 tck = 1'b1;
    #195 t = tdo;
    #5 tck = 1'b0;
    #100;
  endtask
  // position 0 goes in first and comes out first
  task automatic frame(input logic [131:0] din, output logic [131:0] dout);
    #1 {bs_select, capture_dr} = 2'h3;
    tick(b);
    {capture_dr, shift_dr} = 2'h1;
    for (int i = 0; i < 132; i++) begin
      tdi = din[i];
      tick(dout[i]);
    end
    {shift_dr, update_dr} = 2'h1;
    tick(b);
    // released tdi shows the inverse, never a stale level
    {bs_select, update_dr, tdi} = {2'h0, ~tdi};
  endtask
endmodule // scan_tester
`default_nettype wire

// ### dv/boundary_scan_chain_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "scan_chain_defines.vh"
// ****
// port checker
// ****
module boundary_scan_chain_checker (
  // watched ports
  input wire logic        sys_clk, arst_n, bs_select, tdo, tdo_oe,
  input wire logic        hidden_override,
  input wire logic [42:0] hidden_internal_cell,
  input wire logic [4:0]  pin_port_output_bit, pin_direction_bit,
  input wire logic [4:0]  pb_pad_out, pb_pad_oe, pb_pullup_en,
  input wire logic [73:0] low_update
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_reset_safe: assert property ($rose(arst_n) |->
    hidden_internal_cell == `HIDDEN_SAFE) else $error("bad reset");
  chk_observe_only: assert property (low_update[63:60] == 4'h0)
    else $error("observe latch set");
  chk_pins_oe: assert property (!hidden_override |->
    pb_pad_oe == pin_direction_bit) else $error("pad oe");
  chk_pins_out: assert property (!hidden_override |->
    pb_pad_out == pin_port_output_bit) else $error("pad out");
  chk_pull_term: assert property (!hidden_override |->
    pb_pullup_en == (pin_port_output_bit & ~pin_direction_bit))
    else $error("pull-up");
  chk_idle_tdo: assert property (!bs_select [*8] |-> $stable(tdo))
    else $error("tdo moved");
  chk_idle_hidden: assert property (!bs_select [*8] |->
    $stable(hidden_internal_cell)) else $error("hidden moved");
  chk_idle_low: assert property (!bs_select [*8] |->
    $stable(low_update)) else $error("latch moved");
  cover property (hidden_override);
  cover property ($rose(tdo_oe));
  cover property ($changed(low_update));
endmodule // boundary_scan_chain_checker
bind boundary_scan_chain boundary_scan_chain_checker
  boundary_scan_chain_checker_i (.*);
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scan_chain_defines.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t mismatch", $time); end end
// ****
// bench top
// ****
module tb_top;
  logic sys_clk = 1'b0, arst_n = 1'b0, extest_mode = 1'b0, tck, tdi, tdo;
  logic bs_select, capture_dr, shift_dr, update_dr, tdo_oe, hidden_override;
  logic [42:0] hidden_capture = 43'h5a5_5a5a_5a5a, hidden_internal_cell, hr;
  logic [4:0] pin_port_output_bit = 5'h0c, pin_direction_bit = 5'h0a;
  logic [4:0] pb_pad_in = 5'h15, pb_pad_out, pb_pad_oe, pb_pullup_en;
  logic [73:0] low_capture = 74'h2a5_5555_aaaa_3c3c_c3c3, low_update;
  logic [131:0] din, dout, exp;
  int mismatches = 0, comparisons = 0;
  int safe_cells[7] = '{0, 11, 21, 25, 34, 38, 39};
  boundary_scan_chain boundary_scan_chain_i (.*);
  scan_tester scan_tester_i (.*);
  initial forever #25 sys_clk = ~sys_clk;
  // hidden latches leave reset holding the safe pattern
  task automatic t_reset_safe();
    hr = '0;
    foreach (safe_cells[k])
      hr[safe_cells[k]] = 1'b1;
    `CHK(hidden_internal_cell, hr)
    `CHK(tdo_oe, 1'b0)
  endtask
  task automatic t_capture_update();
    hr = {<<{hidden_capture}};
    exp = {hr, 15'h0, low_capture};
    for (int n = 0; n < 5; n++)
      exp[88-3*n -: 3] = {pb_pad_in[n], pin_direction_bit[n],
        pin_direction_bit[n] | ~pin_port_output_bit[n]};
    // safe hidden values go in before every update
    hr = {<<{`HIDDEN_SAFE}};
    din = {hr, 15'h1234, 74'h3_f0a5_0000_0000_8001};
    scan_tester_i.frame(din, dout);
    repeat (8) @(posedge sys_clk);
    `CHK(dout, exp)
    `CHK(hidden_internal_cell, `HIDDEN_SAFE)
    `CHK(low_update, 74'h3_00a5_0000_0000_8001)
    `CHK(tdo_oe, 1'b0)
    `CHK(pb_pad_out, pin_port_output_bit)
    `CHK(pb_pad_oe, pin_direction_bit)
    `CHK(pb_pullup_en, pin_port_output_bit & ~pin_direction_bit)
    `CHK(hidden_override, 1'b0)
  endtask
  // safe hidden preload, latches then drive the pins
  task automatic t_extest();
    #1 extest_mode = 1'b1;
    hr = {<<{`HIDDEN_SAFE}};
    din = {hr, 15'h6b5a, 74'h0};
    scan_tester_i.frame(din, dout);
    repeat (8) @(posedge sys_clk);
    `CHK(hidden_internal_cell, `HIDDEN_SAFE)
    for (int n = 0; n < 5; n++) begin
      `CHK(pb_pad_out[n], din[88-3*n])
      `CHK(pb_pad_oe[n], din[87-3*n])
      `CHK(pb_pullup_en[n], ~din[86-3*n])
    end
    `CHK(hidden_override, 1'b1)
    #1 extest_mode = 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset_safe();
    t_capture_update();
    t_extest();
    wrap_up();
  end
  // two frames take about 110 us
  initial begin
    #300us;
    mismatches++;
    wrap_up();
  end
  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
endmodule // tb_top
`default_nettype wire
